/* File: verilog/adcc_pkg.sv */
`default_nettype none
package adcc_pkg;

  // Register offsets on the control port.
  localparam logic [7:0] ADDR_FAULT_DET = 8'h43;
  localparam logic [7:0] ADDR_OVLD_MUTE = 8'h4b;
  localparam logic [7:0] ADDR_ADC_TUNE = 8'h4e;
  localparam logic [7:0] ADDR_DAC_TUNE = 8'h4f;
  localparam logic [7:0] ADDR_CH1_INPUT = 8'h50;
  localparam logic [7:0] ADDR_CH1_VOL = 8'h52;
  localparam logic [7:0] ADDR_CH1_FGAIN = 8'h53;
  localparam logic [7:0] ADDR_CH1_PCAL = 8'h54;
  localparam logic [7:0] ADDR_CH2_INPUT = 8'h55;

  // Writable bits of each register; all other bits are reserved.
  localparam logic [7:0] MASK_FAULT_DET = 8'h03;
  localparam logic [7:0] MASK_OVLD_MUTE = 8'h18;
  localparam logic [7:0] MASK_ADC_TUNE = 8'he4;
  localparam logic [7:0] MASK_DAC_TUNE = 8'ha6;
  localparam logic [7:0] MASK_CH1_INPUT = 8'hc3;
  localparam logic [7:0] MASK_CH1_VOL = 8'hff;
  localparam logic [7:0] MASK_CH1_FGAIN = 8'hf0;
  localparam logic [7:0] MASK_CH1_PCAL = 8'hff;
  localparam logic [7:0] MASK_CH2_INPUT = 8'hc0;

  // Reset values.
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_CH1_VOL = 8'ha1;
  localparam logic [7:0] RST_CH1_FGAIN = 8'h80;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Field positions.
  localparam int BIT_DRV_FLT_DIS = 1;
  localparam int BIT_AREG_SC_DIS = 0;
  localparam int BIT_CH1_OVLD = 4;
  localparam int BIT_CH2_OVLD = 3;
  localparam int BIT_CLK_HALVE = 7;
  localparam int BIT_CIC_ORDER = 6;
  localparam int BIT_FIR_SKIP = 5;
  localparam int BIT_LOW_PWR = 2;
  localparam int BIT_IREF_SEL = 1;
  localparam int SRC_MSB = 7;
  localparam int SRC_LSB = 6;
  localparam int BIT_FULL_SCALE = 1;
  localparam int BIT_BANDWIDTH = 0;
  localparam int FGAIN_MSB = 7;
  localparam int FGAIN_LSB = 4;
  localparam int PCAL_MSB = 7;
  localparam int PCAL_LSB = 2;
  localparam int SCOPE_MSB = 1;
  localparam int SCOPE_LSB = 0;

  // Field codes.
  localparam logic [7:0] VOL_MUTE_CODE = 8'h00;
  localparam logic [7:0] VOL_UNITY_CODE = 8'ha1;
  localparam logic [3:0] FGAIN_UNITY_CODE = 4'h8;
  localparam logic [2:0] CIC_ORDER_FIFTH = 3'h5;
  localparam logic [2:0] CIC_ORDER_FOURTH = 3'h4;
  localparam logic [1:0] SRC_SINGLE = 2'h1;
  localparam logic [1:0] SCOPE_BOTH = 2'h0;
  localparam logic [1:0] SCOPE_ANA = 2'h1;
  localparam logic [1:0] SCOPE_DIG = 2'h2;

  // Modulator clock rates in kHz against the 40 MHz system clock.
  localparam logic [16:0] SYS_CLK_KHZ = 17'h09c40;
  localparam logic [16:0] MOD_FULL_KHZ = 17'h00bb8;
  localparam logic [16:0] MOD_HALF_KHZ = 17'h005dc;

  // Phase delay sequencer states, Gray coded along the path.
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_COUNT = 2'b01,
    PH_FIRE = 2'b11
  } adcc_phase_t;

endpackage
`default_nettype wire

/* File: verilog/adcc_regs.sv */
// Behaviour
// - Driver fault detection runs only while its disable bit is 0.
// - Regulator short flag is reported only while its disable bit is 0.
// - Channel 1 output muted during its overload recovery when bit 4 set.
// - Channel 2 output muted during its overload recovery when bit 3 set.
// - ADC modulator clock runs at 3 MHz, or 1.5 MHz when halved.
// - ADC CIC is fifth order at 0, fourth order at 1.
// - ADC FIR decimation stage is skipped when its bypass bit is 1.
// - ADC low-power filter chosen when bit 2 is 1.
// - DAC modulator clock runs at 3 MHz, or 1.5 MHz when halved.
// - DAC FIR and segmenter both skipped when their bypass bit is 1.
// - DAC low-power filter chosen when its bit is 1.
// - Channel 1 source: 0 differential, 1 single-ended; host avoids 2, 3.
// - Channel 2 source at bits 7:6, same coding; host avoids 2 and 3.
// - Channel 1 full scale is 10 Vrms at 0, 5 Vrms at 1.
// - Channel 1 bandwidth is 24 kHz mode at 0, 96 kHz at 1.
// - Volume 0 mutes; 1 is -80 dB, 161 is 0 dB, 255 is +47 dB.
// - Fine gain -0.8 dB at 0, 0 dB at 8, 0.1 dB per code.
// - Phase calibration delays channel 1 by 0 to 63 modulator cycles.
// - Phase scope: 0 both paths, 1 analog, 2 digital; host avoids 3.
// - Reserved bits read as zero; host writes only their reset value.
`timescale 1ns/1ps
`default_nettype none

// Fractional divider giving one-cycle ticks at the modulator clock rate.
module adcc_mod_tick
  import adcc_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Rate select and tick.
  input wire logic halve,
  output logic tick
);
  logic [16:0] acc_reg;
  logic [16:0] acc_next;
  logic tick_reg;
  logic tick_next;
  logic [16:0] sum;

  // Adds the target rate each cycle and wraps at the system rate.
  always_comb begin
    sum = acc_reg + (halve ? MOD_HALF_KHZ : MOD_FULL_KHZ);
    if (sum >= SYS_CLK_KHZ) begin
      acc_next = sum - SYS_CLK_KHZ;
      tick_next = 1'b1;
    end else begin
      acc_next = sum;
      tick_next = 1'b0;
    end
  end

  // Registers the accumulator and the tick.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule

module adcc_regs
  import adcc_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Control port register access.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rdata,
  // Raw fault detectors.
  input wire logic driver_vg_fault_raw,
  input wire logic driver_sc_fault_raw,
  input wire logic regulator_short_raw,
  output logic driver_fault_det,
  output logic regulator_short_flag,
  // Overload recovery and mutes.
  input wire logic ch1_overload_recovery,
  input wire logic ch2_overload_recovery,
  output logic ch1_overload_muted,
  output logic ch2_overload_muted,
  // ADC power tune.
  output logic adc_mod_tick,
  output logic [2:0] adc_decim_order,
  output logic adc_fir_skip,
  output logic adc_low_power_filter,
  // DAC power tune.
  output logic dac_mod_tick,
  output logic dac_fir_segmenter_skip,
  output logic dac_low_power_filter,
  output logic dac_current_ref_sel,
  // Channel 1 analog setup.
  output logic [1:0] ch1_input_source,
  output logic ch1_single_ended,
  output logic ch1_full_scale_sel,
  output logic ch1_bandwidth_sel,
  // Channel 1 gain.
  output logic ch1_volume_mute,
  output logic signed [8:0] ch1_volume_half_db,
  output logic signed [4:0] ch1_fine_gain_tenth_db,
  // Channel 1 phase calibration.
  output logic [5:0] ch1_phase_delay,
  output logic ch1_pcal_analog_en,
  output logic ch1_pcal_digital_en,
  input wire logic ch1_frame_start,
  output logic ch1_frame_start_delayed,
  // Channel 2 source.
  output logic [1:0] ch2_input_source,
  output logic ch2_single_ended
);

  logic [7:0] fault_detect_cfg_reg;
  logic [7:0] fault_detect_cfg_next;
  logic [7:0] adc_overload_mute_cfg_reg;
  logic [7:0] adc_overload_mute_cfg_next;
  logic [7:0] adc_power_tune_cfg_reg;
  logic [7:0] adc_power_tune_cfg_next;
  logic [7:0] dac_power_tune_cfg_reg;
  logic [7:0] dac_power_tune_cfg_next;
  logic [7:0] adc_ch1_input_cfg_reg;
  logic [7:0] adc_ch1_input_cfg_next;
  logic [7:0] adc_ch1_volume_reg;
  logic [7:0] adc_ch1_volume_next;
  logic [7:0] adc_ch1_fine_gain_reg;
  logic [7:0] adc_ch1_fine_gain_next;
  logic [7:0] adc_ch1_phase_cal_reg;
  logic [7:0] adc_ch1_phase_cal_next;
  logic [7:0] adc_ch2_input_cfg_reg;
  logic [7:0] adc_ch2_input_cfg_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  adcc_phase_t ph_state_reg;
  adcc_phase_t ph_state_next;
  logic [5:0] ph_count_reg;
  logic [5:0] ph_count_next;
  logic [5:0] ph_target;
  logic [1:0] pcal_scope;

  // Register writes keep only writable bits, so reserved bits stay zero.
  always_comb begin
    fault_detect_cfg_next = fault_detect_cfg_reg;
    adc_overload_mute_cfg_next = adc_overload_mute_cfg_reg;
    adc_power_tune_cfg_next = adc_power_tune_cfg_reg;
    dac_power_tune_cfg_next = dac_power_tune_cfg_reg;
    adc_ch1_input_cfg_next = adc_ch1_input_cfg_reg;
    adc_ch1_volume_next = adc_ch1_volume_reg;
    adc_ch1_fine_gain_next = adc_ch1_fine_gain_reg;
    adc_ch1_phase_cal_next = adc_ch1_phase_cal_reg;
    adc_ch2_input_cfg_next = adc_ch2_input_cfg_reg;
    if (reg_wr_en) begin
      case (reg_addr)
        ADDR_FAULT_DET: fault_detect_cfg_next = reg_wdata & MASK_FAULT_DET;
        ADDR_OVLD_MUTE: begin
          adc_overload_mute_cfg_next = reg_wdata & MASK_OVLD_MUTE;
        end
        ADDR_ADC_TUNE: adc_power_tune_cfg_next = reg_wdata & MASK_ADC_TUNE;
        ADDR_DAC_TUNE: dac_power_tune_cfg_next = reg_wdata & MASK_DAC_TUNE;
        ADDR_CH1_INPUT: adc_ch1_input_cfg_next = reg_wdata & MASK_CH1_INPUT;
        ADDR_CH1_VOL: adc_ch1_volume_next = reg_wdata & MASK_CH1_VOL;
        ADDR_CH1_FGAIN: adc_ch1_fine_gain_next = reg_wdata & MASK_CH1_FGAIN;
        ADDR_CH1_PCAL: adc_ch1_phase_cal_next = reg_wdata & MASK_CH1_PCAL;
        ADDR_CH2_INPUT: adc_ch2_input_cfg_next = reg_wdata & MASK_CH2_INPUT;
        default: begin
        end
      endcase
    end
  end

  // Read data is captured on a read strobe; unmapped offsets read zero.
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd_en) begin
      case (reg_addr)
        ADDR_FAULT_DET: rdata_next = fault_detect_cfg_reg;
        ADDR_OVLD_MUTE: rdata_next = adc_overload_mute_cfg_reg;
        ADDR_ADC_TUNE: rdata_next = adc_power_tune_cfg_reg;
        ADDR_DAC_TUNE: rdata_next = dac_power_tune_cfg_reg;
        ADDR_CH1_INPUT: rdata_next = adc_ch1_input_cfg_reg;
        ADDR_CH1_VOL: rdata_next = adc_ch1_volume_reg;
        ADDR_CH1_FGAIN: rdata_next = adc_ch1_fine_gain_reg;
        ADDR_CH1_PCAL: rdata_next = adc_ch1_phase_cal_reg;
        ADDR_CH2_INPUT: rdata_next = adc_ch2_input_cfg_reg;
        default: rdata_next = READ_UNMAPPED;
      endcase
    end
  end

  // Registers the bank and the read data.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fault_detect_cfg_reg <= RST_ZERO;
      adc_overload_mute_cfg_reg <= RST_ZERO;
      adc_power_tune_cfg_reg <= RST_ZERO;
      dac_power_tune_cfg_reg <= RST_ZERO;
      adc_ch1_input_cfg_reg <= RST_ZERO;
      adc_ch1_volume_reg <= RST_CH1_VOL;
      adc_ch1_fine_gain_reg <= RST_CH1_FGAIN;
      adc_ch1_phase_cal_reg <= RST_ZERO;
      adc_ch2_input_cfg_reg <= RST_ZERO;
      rdata_reg <= RST_ZERO;
    end else begin
      fault_detect_cfg_reg <= fault_detect_cfg_next;
      adc_overload_mute_cfg_reg <= adc_overload_mute_cfg_next;
      adc_power_tune_cfg_reg <= adc_power_tune_cfg_next;
      dac_power_tune_cfg_reg <= dac_power_tune_cfg_next;
      adc_ch1_input_cfg_reg <= adc_ch1_input_cfg_next;
      adc_ch1_volume_reg <= adc_ch1_volume_next;
      adc_ch1_fine_gain_reg <= adc_ch1_fine_gain_next;
      adc_ch1_phase_cal_reg <= adc_ch1_phase_cal_next;
      adc_ch2_input_cfg_reg <= adc_ch2_input_cfg_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // Fault detection gated by the disable bits.
  assign driver_fault_det = !fault_detect_cfg_reg[BIT_DRV_FLT_DIS] &&
    (driver_vg_fault_raw || driver_sc_fault_raw);
  assign regulator_short_flag = !fault_detect_cfg_reg[BIT_AREG_SC_DIS] &&
    regulator_short_raw;

  // Mutes held for as long as each converter is recovering.
  assign ch1_overload_muted = adc_overload_mute_cfg_reg[BIT_CH1_OVLD] &&
    ch1_overload_recovery;
  assign ch2_overload_muted = adc_overload_mute_cfg_reg[BIT_CH2_OVLD] &&
    ch2_overload_recovery;

  // One divider per converter, so each rate is chosen on its own.
  adcc_mod_tick u_adc_tick (
    .clk(clk),
    .sys_rst(sys_rst),
    .halve(adc_power_tune_cfg_reg[BIT_CLK_HALVE]),
    .tick(adc_mod_tick)
  );

  adcc_mod_tick u_dac_tick (
    .clk(clk),
    .sys_rst(sys_rst),
    .halve(dac_power_tune_cfg_reg[BIT_CLK_HALVE]),
    .tick(dac_mod_tick)
  );

  // ADC and DAC filter path selections.
  assign adc_decim_order = adc_power_tune_cfg_reg[BIT_CIC_ORDER] ?
    CIC_ORDER_FOURTH : CIC_ORDER_FIFTH;
  assign adc_fir_skip = adc_power_tune_cfg_reg[BIT_FIR_SKIP];
  assign adc_low_power_filter = adc_power_tune_cfg_reg[BIT_LOW_PWR];
  assign dac_fir_segmenter_skip =
    dac_power_tune_cfg_reg[BIT_FIR_SKIP];
  assign dac_low_power_filter =
    dac_power_tune_cfg_reg[BIT_LOW_PWR];
  assign dac_current_ref_sel = dac_power_tune_cfg_reg[BIT_IREF_SEL];

  // Input sources; codes 2 and 3 are stored but decode as not single-ended, like code 0.
  assign ch1_input_source = adc_ch1_input_cfg_reg[SRC_MSB:SRC_LSB];
  assign ch1_single_ended = (ch1_input_source == SRC_SINGLE);
  assign ch2_input_source = adc_ch2_input_cfg_reg[SRC_MSB:SRC_LSB];
  assign ch2_single_ended = (ch2_input_source == SRC_SINGLE);
  assign ch1_full_scale_sel =
    adc_ch1_input_cfg_reg[BIT_FULL_SCALE];
  assign ch1_bandwidth_sel = adc_ch1_input_cfg_reg[BIT_BANDWIDTH];

  // Gains in signed half-dB and tenth-dB units about their unity codes.
  assign ch1_volume_mute = (adc_ch1_volume_reg == VOL_MUTE_CODE);
  assign ch1_volume_half_db = $signed({1'b0, adc_ch1_volume_reg}) -
    $signed({1'b0, VOL_UNITY_CODE});
  assign ch1_fine_gain_tenth_db =
    $signed({1'b0, adc_ch1_fine_gain_reg[FGAIN_MSB:FGAIN_LSB]}) -
    $signed({1'b0, FGAIN_UNITY_CODE});

  // Phase calibration scope; the reserved code enables neither path.
  assign pcal_scope = adc_ch1_phase_cal_reg[SCOPE_MSB:SCOPE_LSB];
  assign ch1_pcal_analog_en = (pcal_scope == SCOPE_BOTH) ||
    (pcal_scope == SCOPE_ANA);
  assign ch1_pcal_digital_en = (pcal_scope == SCOPE_BOTH) ||
    (pcal_scope == SCOPE_DIG);
  assign ch1_phase_delay = adc_ch1_phase_cal_reg[PCAL_MSB:PCAL_LSB];
  assign ph_target = ch1_pcal_digital_en ? ch1_phase_delay : '0;

  // Delays the frame strobe by the set number of modulator ticks when the digital path is in scope, else not at all.
  always_comb begin
    ph_state_next = ph_state_reg;
    ph_count_next = ph_count_reg;
    case (ph_state_reg)
      PH_IDLE: begin
        ph_count_next = '0;
        if (ch1_frame_start) begin
          ph_state_next = (ph_target == '0) ? PH_FIRE : PH_COUNT;
        end
      end
      PH_COUNT: begin
        if (adc_mod_tick) begin
          ph_count_next = ph_count_reg + 6'h01;
          if (ph_count_reg + 6'h01 >= ph_target) begin
            ph_state_next = PH_FIRE;
          end
        end
      end
      PH_FIRE: ph_state_next = PH_IDLE;
      default: ph_state_next = PH_IDLE;
    endcase
  end

  // Registers the phase sequencer.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ph_state_reg <= PH_IDLE;
      ph_count_reg <= '0;
    end else begin
      ph_state_reg <= ph_state_next;
      ph_count_reg <= ph_count_next;
    end
  end

  assign ch1_frame_start_delayed = (ph_state_reg == PH_FIRE);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_write(logic [7:0] addr, int bitpos);
    reg_wr_en && reg_addr == addr && reg_wdata[bitpos];
  endsequence

  a_drv_fault_off: assert property (
    s_write(ADDR_FAULT_DET, BIT_DRV_FLT_DIS) |=> !driver_fault_det)
    else $error("driver fault seen while detection disabled");
  a_areg_short_off: assert property (
    s_write(ADDR_FAULT_DET, BIT_AREG_SC_DIS) |=> !regulator_short_flag)
    else $error("regulator short flagged while detection disabled");
  a_ch1_ovld_mute: assert property (
    s_write(ADDR_OVLD_MUTE, BIT_CH1_OVLD) ##1 ch1_overload_recovery
    |-> ch1_overload_muted)
    else $error("channel 1 not muted in overload recovery");
  a_ch2_ovld_mute: assert property (
    s_write(ADDR_OVLD_MUTE, BIT_CH2_OVLD) ##1 ch2_overload_recovery
    |-> ch2_overload_muted)
    else $error("channel 2 not muted in overload recovery");
  a_adc_tick_gap: assert property (
    adc_mod_tick |=> !adc_mod_tick [*8])
    else $error("adc modulator ticks too close");
  a_dac_tick_gap: assert property (
    dac_mod_tick |-> ##[13:27] dac_mod_tick)
    else $error("dac modulator tick spacing wrong");
  a_cic_fourth: assert property (
    s_write(ADDR_ADC_TUNE, BIT_CIC_ORDER) |=>
    adc_decim_order == CIC_ORDER_FOURTH)
    else $error("cic order not fourth after write");
  a_vol_lowest: assert property (
    reg_wr_en && reg_addr == ADDR_CH1_VOL && reg_wdata == 8'h01 |=>
    ch1_volume_half_db == -9'sd160 && !ch1_volume_mute)
    else $error("volume code 1 not at -80 dB");
  a_fgain_lowest: assert property (
    reg_wr_en && reg_addr == ADDR_CH1_FGAIN && reg_wdata[7:4] == 4'h0 |=>
    ch1_fine_gain_tenth_db == -5'sd8)
    else $error("fine gain code 0 not at -0.8 dB");
  a_pcal_scope_bad: assert property (
    reg_wr_en && reg_addr == ADDR_CH1_PCAL && reg_wdata[1:0] == 2'h3 |=>
    !ch1_pcal_analog_en && !ch1_pcal_digital_en)
    else $error("reserved scope code enabled a path");
  a_reserved_zero: assert property (
    reg_rd_en && reg_addr == ADDR_OVLD_MUTE |=>
    (reg_rdata & ~MASK_OVLD_MUTE) == 8'h00)
    else $error("reserved bits read nonzero");

endmodule
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
  import adcc_pkg::*;
;
  logic clk, sys_rst, reg_wr_en, reg_rd_en, ch1_frame_start;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic drv_vg, drv_sc, areg_sc, rec1, rec2;
  logic drv_det, areg_flag, mute1, mute2, adc_tick, dac_tick;
  logic [2:0] order;
  logic adc_skip, adc_lp, dac_skip, dac_lp, dac_iref;
  logic [1:0] src1, src2;
  logic se1, se2, fs1, bw1, vmute, pan, pdig, delayed;
  logic signed [8:0] vol_hdb;
  logic signed [4:0] fg_tdb;
  logic [5:0] pdel;
  logic [7:0] rv;
  int errors, compares, span;
  logic [7:0] addrs [9] = '{ADDR_FAULT_DET, ADDR_OVLD_MUTE, ADDR_ADC_TUNE,
    ADDR_DAC_TUNE, ADDR_CH1_INPUT, ADDR_CH1_VOL, ADDR_CH1_FGAIN,
    ADDR_CH1_PCAL, ADDR_CH2_INPUT};
  logic [7:0] masks [9] = '{8'h03, 8'h18, 8'he4, 8'ha6, 8'hc3, 8'hff,
    8'hf0, 8'hff, 8'hc0};
  logic [7:0] rsts [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'ha1,
    8'h80, 8'h00, 8'h00};
  int vcode [6] = '{0, 1, 2, 161, 162, 255};
  int vexp [6] = '{-161, -160, -159, 0, 1, 94};
  int gcode [4] = '{0, 8, 9, 15};
  int gexp [4] = '{-8, 0, 1, 7};

  adcc_regs adcc_regs_inst (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
    .driver_vg_fault_raw(drv_vg), .driver_sc_fault_raw(drv_sc),
    .regulator_short_raw(areg_sc), .driver_fault_det(drv_det),
    .regulator_short_flag(areg_flag), .ch1_overload_recovery(rec1),
    .ch2_overload_recovery(rec2), .ch1_overload_muted(mute1),
    .ch2_overload_muted(mute2), .adc_mod_tick(adc_tick),
    .adc_decim_order(order), .adc_fir_skip(adc_skip),
    .adc_low_power_filter(adc_lp), .dac_mod_tick(dac_tick),
    .dac_fir_segmenter_skip(dac_skip), .dac_low_power_filter(dac_lp),
    .dac_current_ref_sel(dac_iref), .ch1_input_source(src1),
    .ch1_single_ended(se1), .ch1_full_scale_sel(fs1),
    .ch1_bandwidth_sel(bw1), .ch1_volume_mute(vmute),
    .ch1_volume_half_db(vol_hdb), .ch1_fine_gain_tenth_db(fg_tdb),
    .ch1_phase_delay(pdel), .ch1_pcal_analog_en(pan),
    .ch1_pcal_digital_en(pdig), .ch1_frame_start(ch1_frame_start),
    .ch1_frame_start_delayed(delayed), .ch2_input_source(src2),
    .ch2_single_ended(se2));

  // Free-running 40 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Compares a seen value with the expected one.
  task automatic chk(input string what, input logic [8:0] seen,
                     input logic [8:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One write strobe on the control port.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge clk);
    reg_wr_en <= 1'b0;
  endtask

  // One read strobe; data is taken once the answer has settled.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  // Cycles spanned by three consecutive modulator tick gaps.
  task automatic tick_span(input bit use_dac, output int s);
    int n, k;
    n = 0;
    s = 0;
    for (k = 0; k < 400 && n < 4; k++) begin
      @(negedge clk);
      if (n > 0) s++;
      if ((use_dac ? dac_tick : adc_tick) === 1'b1) n++;
    end
    if (n < 4) begin
      errors++;
      report_and_stop();
    end
  endtask

  // Frame start with a given phase code and scope; checks the delay.
  task automatic phase(input logic [5:0] d, input logic [1:0] sc,
                       input int exp_ticks);
    int k, t, last;
    wr(ADDR_CH1_PCAL, {d, sc});
    @(posedge clk);
    ch1_frame_start <= 1'b1;
    @(posedge clk);
    ch1_frame_start <= 1'b0;
    t = 0;
    last = 0;
    for (k = 1; k < 2000; k++) begin
      @(negedge clk);
      if (delayed === 1'b1) break;
      if (adc_tick === 1'b1) begin
        t++;
        last = k;
      end
    end
    if (k >= 2000) begin
      errors++;
      report_and_stop();
    end
    chk("tick count", 9'(t), 9'(exp_ticks));
    chk("pulse cycle", 9'(k), 9'(last + 1));
    @(negedge clk);
    chk("pulse width", 9'(delayed), 9'h000);
  endtask

  initial begin
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    {drv_vg, drv_sc, areg_sc, rec1, rec2, ch1_frame_start} = 6'h00;
    errors = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    // Reset values, write masks and an unmapped offset.
    for (int i = 0; i < 9; i++) begin
      rd(addrs[i], rv);
      chk("reset value", 9'(rv), 9'(rsts[i]));
      wr(addrs[i], 8'hff);
      rd(addrs[i], rv);
      chk("masked write", 9'(rv), 9'(masks[i]));
    end
    wr(8'h51, 8'hff);
    rd(8'h51, rv);
    chk("unmapped read", 9'(rv), 9'(READ_UNMAPPED));
    chk("cic order 4", 9'(order), 9'(CIC_ORDER_FOURTH));
    chk("adc fir", 9'(adc_skip), 9'h001);
    chk("adc lp", 9'(adc_lp), 9'h001);
    chk("dac skip", 9'(dac_skip), 9'h001);
    chk("dac lp", 9'(dac_lp), 9'h001);
    chk("src1 code3", 9'({src1, se1}), 9'h006);
    chk("src2 code3", 9'({src2, se2}), 9'h006);
    for (int i = 0; i < 9; i++) wr(addrs[i], 8'h00);
    @(negedge clk);
    chk("cic order 5", 9'(order), 9'(CIC_ORDER_FIFTH));
    chk("tune off", 9'({adc_skip, adc_lp, dac_skip, dac_lp}), 9'h0);
    $display("register map test done");
    // Fault detection with and without its disable bits.
    @(posedge clk);
    drv_vg <= 1'b1;
    areg_sc <= 1'b1;
    @(negedge clk);
    chk("vg fault", 9'(drv_det), 9'h001);
    chk("areg flag", 9'(areg_flag), 9'h001);
    wr(ADDR_FAULT_DET, 8'h03);
    drv_vg <= 1'b0;
    drv_sc <= 1'b1;
    @(negedge clk);
    chk("drv masked", 9'(drv_det), 9'h000);
    chk("areg masked", 9'(areg_flag), 9'h000);
    wr(ADDR_FAULT_DET, 8'h01);
    @(negedge clk);
    chk("sc fault", 9'(drv_det), 9'h001);
    chk("areg still off", 9'(areg_flag), 9'h000);
    $display("fault test done");
    // Overload mute per channel.
    @(posedge clk);
    rec1 <= 1'b1;
    rec2 <= 1'b1;
    @(negedge clk);
    chk("no mute", 9'({mute1, mute2}), 9'h0);
    wr(ADDR_OVLD_MUTE, 8'h10);
    @(negedge clk);
    chk("mute ch1", 9'({mute1, mute2}), 9'h2);
    wr(ADDR_OVLD_MUTE, 8'h08);
    @(negedge clk);
    chk("mute ch2", 9'({mute1, mute2}), 9'h1);
    @(posedge clk);
    rec2 <= 1'b0;
    @(negedge clk);
    chk("recovered", 9'(mute2), 9'h0);
    $display("overload mute test done");
    // Modulator tick rates, full and halved.
    tick_span(1'b0, span);
    chk("adc 3 MHz", 9'(span), 9'd40);
    tick_span(1'b1, span);
    chk("dac 3 MHz", 9'(span), 9'd40);
    wr(ADDR_ADC_TUNE, 8'h80);
    wr(ADDR_DAC_TUNE, 8'h82);
    tick_span(1'b0, span);
    chk("adc 1.5 MHz", 9'(span), 9'd80);
    tick_span(1'b1, span);
    chk("dac 1.5 MHz", 9'(span), 9'd80);
    chk("iref", 9'(dac_iref), 9'h001);
    wr(ADDR_ADC_TUNE, 8'h00);
    $display("clock rate test done");
    // Channel sources, full scale and bandwidth.
    wr(ADDR_CH1_INPUT, 8'h03);
    @(negedge clk);
    chk("fs and bw", 9'({se1, fs1, bw1}), 9'h3);
    wr(ADDR_CH1_INPUT, 8'h40);
    wr(ADDR_CH2_INPUT, 8'h40);
    @(negedge clk);
    chk("ch1 single", 9'({src1, se1, fs1, bw1}), 9'h0c);
    chk("ch2 single", 9'({src2, se2}), 9'h3);
    $display("input setup test done");
    // Volume and fine gain codes.
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_CH1_VOL, 8'(vcode[i]));
      @(negedge clk);
      chk("volume", vol_hdb, 9'(vexp[i]));
      chk("vol mute", 9'(vmute), 9'(vcode[i] == 0));
    end
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CH1_FGAIN, {4'(gcode[i]), 4'h0});
      @(negedge clk);
      chk("fine gain", fg_tdb, 9'(gexp[i]));
    end
    $display("gain test done");
    // Phase calibration scope decode and delay.
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CH1_PCAL, {6'h2a, 2'(i)});
      @(negedge clk);
      chk("pcal delay", 9'(pdel), 9'h02a);
      chk("scope", 9'({pan, pdig}), 9'(i == 0 ? 3 : i == 1 ? 2 :
                                         i == 2 ? 1 : 0));
    end
    phase(6'd0, SCOPE_DIG, 0);
    phase(6'd5, SCOPE_DIG, 5);
    phase(6'd5, SCOPE_ANA, 0);
    phase(6'd63, SCOPE_BOTH, 63);
    $display("phase test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
